/* File: hdl/rail_seq_defs.vh */
/*
 * Constants for the rail sequencing controller: register offsets, field positions,
 * reset values, bus addresses and timing counts.
 * Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
 */
`ifndef RAIL_SEQ_DEFS_VH
`define RAIL_SEQ_DEFS_VH

`define CLK_HZ            100000000
`define CLKS_PER_MS       (`CLK_HZ / 1000)
`define INIT_TIME_MS      70
`define INIT_CYCLES       (`INIT_TIME_MS * `CLKS_PER_MS)
`define RESTART_EXTRA_MS  18'h00088
`define RESTART_MAX_MS    16'hFFF0
`define MS_TICK_LAST      17'h1869F
`define RISE_MIN_US       250
`define PG_FILTER_US      60
`define PG_FILTER_CYCLES  (`PG_FILTER_US * (`CLK_HZ / 1000000))
`define SHARE_TIMEOUT     16'h0400

`define ADDR_RECOVERY     7'h7C
`define ADDR_GLOBAL0      7'h5A
`define ADDR_GLOBAL1      7'h5B

`define REG_CONTROL       6'h00
`define REG_STATUS        6'h04
`define REG_GLOBAL_CFG    6'h08
`define REG_CHAN_CFG      6'h0C
`define REG_TON_DELAY     6'h10
`define REG_TON_RISE      6'h14
`define REG_TON_MAX       6'h18
`define REG_TOFF_DELAY    6'h1C
`define REG_TOFF_FALL     6'h20
`define REG_RESTART       6'h24
`define REG_ADDR          6'h28

`define CTL_ON0           0
`define CTL_ON1           1
`define CTL_RESTORE       2
`define CTL_VRESET        3
`define CTL_SOFT_OFF      4
`define GCFG_IGNORE_RES   6
`define CCFG_SHARE_REQ    2
`define CCFG_CASCADE      3
`define ST_CML            0
`define ST_CRC_ERR        1
`define ST_INIT_DONE      2

`define GCFG_RESET        8'h00
`define CCFG_RESET        8'h00
`define DEFAULT_ADDR      7'h40

`endif

/* File: hdl/rail_sequencing_control.v */
/*
 * Start-up, sequencing and shutdown controller of a dual-output regulator.
 * Assumes one 100 MHz clock, synchronous active-high reset (undervoltage lockout),
 * a Wishbone master for registers, and analog comparators arriving asynchronously.
 */
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rail_seq_defs.vh"

module rail_sequencing_control #(
  parameter INIT_CYCLES = `INIT_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  input  wire        nvm_load_done_i,
  input  wire        nvm_crc_ok_i,
  input  wire        res_present_i,
  input  wire [3:0]  address_select_input_i,
  input  wire [1:0]  address_select_open_i,
  input  wire        vin_above_on_i,
  input  wire        vin_above_prog_i,
  input  wire [1:0]  run_pin_i,
  input  wire        shared_time_base_i,
  input  wire [1:0]  vout_above_uv_i,
  input  wire [1:0]  overcurrent_i,
  input  wire [1:0]  fault_in_i,
  input  wire [6:0]  bus_addr_i,
  output reg         bus_addr_match_o,
  output reg         nvm_load_o,
  output reg         use_resistors_o,
  output reg  [6:0]  bus_address_o,
  output reg  [1:0]  run_oe_o,
  output reg         alert_oe_o,
  output reg         shared_time_base_oe_o,
  output reg  [1:0]  fault_oe_o,
  output reg  [1:0]  power_good_output_o,
  output reg  [1:0]  pwm_enable_o,
  output reg  [1:0]  force_dcm_o,
  output reg  [1:0]  ramp_down_o,
  output reg  [15:0] target_frac0_o,
  output reg  [15:0] target_frac1_o
);

  localparam [3:0] S_INIT = 4'b0001;
  localparam [3:0] S_LOAD = 4'b0010;
  localparam [3:0] S_WAIT = 4'b0100;
  localparam [3:0] S_RUN  = 4'b1000;

  // Asynchronous inputs, two flops each; only the second stage is read.
  reg [14:0] meta_reg;
  reg [14:0] sync_reg;
  wire [14:0] async_in = {vin_above_on_i, vin_above_prog_i, run_pin_i, shared_time_base_i,
                          vout_above_uv_i, overcurrent_i, fault_in_i, nvm_load_done_i,
                          nvm_crc_ok_i, res_present_i, 1'b0};
  wire       s_vin_on   = sync_reg[14];
  wire       s_vin_prog = sync_reg[13];
  wire [1:0] s_run      = sync_reg[12:11];
  wire       s_share    = sync_reg[10];
  wire [1:0] s_uv       = sync_reg[9:8];
  wire [1:0] s_oc       = sync_reg[7:6];
  wire [1:0] s_fault    = sync_reg[5:4];
  wire       s_nvm_done = sync_reg[3];
  wire       s_crc_ok   = sync_reg[2];
  wire       s_res      = sync_reg[1];

  reg [3:0]  state_reg;
  reg [31:0] init_cnt_reg;
  reg        crc_err_reg;
  reg        cml_reg;
  reg [7:0]  gcfg_reg;
  reg [7:0]  ccfg_reg;
  reg [15:0] ton_delay_reg;
  reg [15:0] ton_rise_reg;
  reg [15:0] ton_max_reg;
  reg [15:0] toff_delay_reg;
  reg [15:0] toff_fall_reg;
  reg [15:0] restart_reg;
  reg [1:0]  on_cmd_reg;
  reg        soft_off_reg;
  reg        reinit_reg;
  reg [15:0] share_idle_reg;
  reg        share_prev_reg;
  reg [16:0] ms_cnt_reg;
  reg        vin_prog_prev_reg;
  reg [1:0]  run_prev_reg;

  wire ready = (state_reg == S_RUN);
  wire ms_tick = (ms_cnt_reg == `MS_TICK_LAST);
  wire share_ok = ~ccfg_reg[`CCFG_SHARE_REQ] | (share_idle_reg < `SHARE_TIMEOUT);
  wire vin_rise = s_vin_prog & ~vin_prog_prev_reg;

  // Restart hold: at least turn-off delay plus fall plus the fixed extra, capped.
  wire [17:0] restart_min = {2'b00, toff_delay_reg} + {2'b00, toff_fall_reg}
                            + `RESTART_EXTRA_MS;
  wire [17:0] restart_want = ({2'b00, restart_reg} > restart_min) ? {2'b00, restart_reg}
                             : restart_min;
  wire [15:0] restart_ms = (restart_want > {2'b00, `RESTART_MAX_MS}) ? `RESTART_MAX_MS
                           : restart_want[15:0];

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  reg         known_adr;
  reg  [31:0] rd_data;
  always @* begin
    known_adr = 1'b1;
    rd_data = 32'h00000000;
    case (wb_adr_i)
      `REG_CONTROL:    rd_data = {27'h0000000, soft_off_reg, 2'b00, on_cmd_reg};
      `REG_STATUS:     rd_data = {29'h00000000, ready, crc_err_reg, cml_reg};
      `REG_GLOBAL_CFG: rd_data = {24'h000000, gcfg_reg};
      `REG_CHAN_CFG:   rd_data = {24'h000000, ccfg_reg};
      `REG_TON_DELAY:  rd_data = {16'h0000, ton_delay_reg};
      `REG_TON_RISE:   rd_data = {16'h0000, ton_rise_reg};
      `REG_TON_MAX:    rd_data = {16'h0000, ton_max_reg};
      `REG_TOFF_DELAY: rd_data = {16'h0000, toff_delay_reg};
      `REG_TOFF_FALL:  rd_data = {16'h0000, toff_fall_reg};
      `REG_RESTART:    rd_data = {16'h0000, restart_reg};
      `REG_ADDR:       rd_data = {25'h0000000, bus_address_o};
      default:         known_adr = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
    share_prev_reg <= s_share;
    vin_prog_prev_reg <= s_vin_prog;
    run_prev_reg <= s_run;
    ms_cnt_reg <= ms_tick ? 17'h00000 : ms_cnt_reg + 17'h00001;
    if (s_share != share_prev_reg)
      share_idle_reg <= 16'h0000;
    else if (share_idle_reg != 16'hFFFF)
      share_idle_reg <= share_idle_reg + 16'h0001;
    if (rst_i) begin
      share_idle_reg <= 16'hFFFF;
      ms_cnt_reg <= 17'h00000;
    end
  end

  // Bus slave: one-cycle answer, sel lane 0 writes, unmapped gets err.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      gcfg_reg <= `GCFG_RESET;
      ccfg_reg <= `CCFG_RESET;
      ton_delay_reg <= 16'h0000;
      ton_rise_reg <= 16'h0000;
      ton_max_reg <= 16'h0000;
      toff_delay_reg <= 16'h0000;
      toff_fall_reg <= 16'h0000;
      restart_reg <= 16'h0000;
      on_cmd_reg <= 2'b00;
      soft_off_reg <= 1'b0;
      reinit_reg <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & known_adr;
      wb_err_o <= wb_req & ~known_adr;
      wb_dat_o <= rd_data;
      reinit_reg <= 1'b0;
      if (wb_wr & known_adr) begin
        case (wb_adr_i)
          `REG_CONTROL: begin
            on_cmd_reg <= wb_dat_i[`CTL_ON1:`CTL_ON0];
            soft_off_reg <= wb_dat_i[`CTL_SOFT_OFF];
            reinit_reg <= wb_dat_i[`CTL_RESTORE] | wb_dat_i[`CTL_VRESET];
          end
          `REG_GLOBAL_CFG: gcfg_reg <= wb_dat_i[7:0];
          `REG_CHAN_CFG:   ccfg_reg <= wb_dat_i[7:0];
          `REG_TON_DELAY:  ton_delay_reg <= wb_dat_i[15:0];
          `REG_TON_RISE:   ton_rise_reg <= wb_dat_i[15:0];
          `REG_TON_MAX:    ton_max_reg <= wb_dat_i[15:0];
          `REG_TOFF_DELAY: toff_delay_reg <= wb_dat_i[15:0];
          `REG_TOFF_FALL:  toff_fall_reg <= wb_dat_i[15:0];
          `REG_RESTART:    restart_reg <= wb_dat_i[15:0];
          default:         restart_reg <= restart_reg;
        endcase
      end
    end
  end

  // Initialization sequence; reset models lockout release.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_INIT;
      init_cnt_reg <= 32'h00000000;
      crc_err_reg <= 1'b0;
      cml_reg <= 1'b0;
      nvm_load_o <= 1'b0;
      use_resistors_o <= 1'b0;
      bus_address_o <= `DEFAULT_ADDR;
      alert_oe_o <= 1'b0;
      shared_time_base_oe_o <= 1'b1;
    end else begin
      nvm_load_o <= 1'b0;
      case (state_reg)
        S_INIT: begin
          shared_time_base_oe_o <= 1'b1;
          init_cnt_reg <= 32'h00000000;
          nvm_load_o <= 1'b1;
          state_reg <= S_LOAD;
        end
        S_LOAD: begin
          if (init_cnt_reg != INIT_CYCLES)
            init_cnt_reg <= init_cnt_reg + 32'h00000001;
          if (s_nvm_done && init_cnt_reg == INIT_CYCLES) begin
            use_resistors_o <= s_res & ~gcfg_reg[`GCFG_IGNORE_RES];
            if (!address_select_open_i[1])
              bus_address_o[6:4] <= {1'b1, address_select_input_i[3:2]};
            if (!address_select_open_i[0])
              bus_address_o[3:0] <= {2'b00, address_select_input_i[1:0]};
            if (!s_crc_ok) begin
              crc_err_reg <= 1'b1;
              cml_reg <= 1'b1;
              alert_oe_o <= 1'b1;
            end
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          shared_time_base_oe_o <= 1'b0;
          if (s_vin_on && !crc_err_reg)
            state_reg <= S_RUN;
        end
        S_RUN: begin
          if (!s_vin_on)
            state_reg <= S_WAIT;
        end
        default: state_reg <= S_INIT;
      endcase
      if (reinit_reg) begin
        state_reg <= S_INIT;
        crc_err_reg <= 1'b0;
        cml_reg <= 1'b0;
        alert_oe_o <= 1'b0;
      end
      bus_addr_match_o <= crc_err_reg ?
        (bus_addr_i == `ADDR_RECOVERY || bus_addr_i == `ADDR_GLOBAL0 ||
         bus_addr_i == `ADDR_GLOBAL1) :
        (bus_addr_i == bus_address_o || bus_addr_i == `ADDR_GLOBAL0 ||
         bus_addr_i == `ADDR_GLOBAL1);
    end
  end

  // Per-channel sequencer.
  localparam [4:0] C_OFF   = 5'b00001;
  localparam [4:0] C_DELAY = 5'b00010;
  localparam [4:0] C_RAMP  = 5'b00100;
  localparam [4:0] C_REG   = 5'b01000;
  localparam [4:0] C_DOWN  = 5'b10000;
  reg [4:0]  ch_state_reg [0:1];
  reg [15:0] ch_ms_reg [0:1];
  reg [15:0] ch_hold_reg [0:1];
  reg [15:0] ch_tmax_reg [0:1];
  reg [31:0] ch_pg_cnt_reg [0:1];
  reg [1:0]  fault_reg;
  integer i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 2; i = i + 1) begin
        ch_state_reg[i] <= C_OFF;
        ch_ms_reg[i] <= 16'h0000;
        ch_hold_reg[i] <= 16'h0000;
        ch_tmax_reg[i] <= 16'h0000;
        ch_pg_cnt_reg[i] <= 32'h00000000;
      end
      fault_reg <= 2'b00;
      run_oe_o <= 2'b11;
      fault_oe_o <= 2'b11;
      power_good_output_o <= 2'b00;
      pwm_enable_o <= 2'b00;
      force_dcm_o <= 2'b11;
      ramp_down_o <= 2'b00;
      target_frac0_o <= 16'h0000;
      target_frac1_o <= 16'h0000;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        fault_reg[i] <= s_fault[i] | (ccfg_reg[`CCFG_CASCADE] && i == 1 && fault_reg[0]);
        fault_oe_o[i] <= ~ready | fault_reg[i];
        // Power-good deglitch: output follows after the filter time.
        if (!ready || s_uv[i] == power_good_output_o[i])
          ch_pg_cnt_reg[i] <= 32'h00000000;
        else
          ch_pg_cnt_reg[i] <= ch_pg_cnt_reg[i] + 32'h00000001;
        if (!ready)
          power_good_output_o[i] <= 1'b0;
        else if (ch_pg_cnt_reg[i] == `PG_FILTER_CYCLES - 1)
          power_good_output_o[i] <= s_uv[i];
        if (ch_hold_reg[i] != 16'h0000) begin
          run_oe_o[i] <= 1'b1;
          if (ms_tick)
            ch_hold_reg[i] <= ch_hold_reg[i] - 16'h0001;
        end else begin
          run_oe_o[i] <= ~ready;
        end
        if (ms_tick && ch_ms_reg[i] != 16'h0000)
          ch_ms_reg[i] <= ch_ms_reg[i] - 16'h0001;
        if (ms_tick && ch_tmax_reg[i] != 16'h0000)
          ch_tmax_reg[i] <= ch_tmax_reg[i] - 16'h0001;
        case (ch_state_reg[i])
          C_OFF: begin
            pwm_enable_o[i] <= 1'b0;
            ramp_down_o[i] <= 1'b0;
            force_dcm_o[i] <= 1'b1;
            if (ready && share_ok && !fault_reg[i] && ch_hold_reg[i] == 16'h0000 &&
                ((s_run[i] && !run_prev_reg[i]) || on_cmd_reg[i] || vin_rise)) begin
              ch_ms_reg[i] <= ton_delay_reg;
              ch_state_reg[i] <= C_DELAY;
            end
          end
          C_DELAY: begin
            if (ch_ms_reg[i] == 16'h0000) begin
              pwm_enable_o[i] <= 1'b1;
              force_dcm_o[i] <= 1'b1;
              ch_tmax_reg[i] <= ton_max_reg;
              ch_ms_reg[i] <= ton_rise_reg;
              // Rise values count down on millisecond ticks; below RISE_MIN_US the ramp is skipped.
              if (ton_rise_reg < `RISE_MIN_US) begin
                if (i == 0) target_frac0_o <= 16'hFFFF;
                else        target_frac1_o <= 16'hFFFF;
                ch_state_reg[i] <= C_REG;
              end else begin
                if (i == 0) target_frac0_o <= 16'h0000;
                else        target_frac1_o <= 16'h0000;
                ch_state_reg[i] <= C_RAMP;
              end
            end
          end
          C_RAMP: begin
            // Linear ramp target: full scale 16'hFFFF less the milliseconds still to count.
            if (i == 0) target_frac0_o <= 16'hFFFF - ch_ms_reg[i];
            else        target_frac1_o <= 16'hFFFF - ch_ms_reg[i];
            if (ch_ms_reg[i] == 16'h0000)
              ch_state_reg[i] <= C_REG;
          end
          C_REG: begin
            if (i == 0) target_frac0_o <= 16'hFFFF;
            else        target_frac1_o <= 16'hFFFF;
            if (ton_max_reg != 16'h0000 ? ch_tmax_reg[i] == 16'h0000
                : (s_uv[i] && !s_oc[i]))
              force_dcm_o[i] <= 1'b0;
          end
          C_DOWN: begin
            if (ch_ms_reg[i] == 16'h0000) begin
              pwm_enable_o[i] <= 1'b0;
              ch_state_reg[i] <= C_OFF;
            end
          end
          default: ch_state_reg[i] <= C_OFF;
        endcase
        if (ch_state_reg[i] != C_OFF && ch_state_reg[i] != C_DOWN &&
            (!ready || fault_reg[i] || !share_ok || (!s_run[i] && run_prev_reg[i]) ||
             (!on_cmd_reg[i] && !s_run[i]))) begin
          ch_hold_reg[i] <= restart_ms;
          if (soft_off_reg && !fault_reg[i] && ready) begin
            ch_ms_reg[i] <= toff_delay_reg + toff_fall_reg;
            ramp_down_o[i] <= 1'b1;
            ch_state_reg[i] <= C_DOWN;
          end else begin
            force_dcm_o[i] <= 1'b1;
            pwm_enable_o[i] <= 1'b0;
            ch_state_reg[i] <= C_OFF;
          end
        end
      end
    end
  end

endmodule

/* File: tb/rail_seq_chk.sv */
/* Assertion checker for rail_sequencing_control, watching only its ports.
   Assumes one clock and a synchronous active-high reset; bound at the foot. */
`timescale 1ns/1ps
`include "rail_seq_defs.vh"
module rail_seq_chk (
  input logic        clk_i,
  input logic        rst_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_ack_o,
  input logic        wb_err_o,
  input logic        vin_above_on_i,
  input logic [1:0]  vout_above_uv_i,
  input logic [6:0]  bus_addr_i,
  input logic        bus_addr_match_o,
  input logic        nvm_load_o,
  input logic [1:0]  run_oe_o,
  input logic        alert_oe_o,
  input logic        shared_time_base_oe_o,
  input logic [1:0]  fault_oe_o,
  input logic [1:0]  power_good_output_o,
  input logic [1:0]  pwm_enable_o,
  input logic [1:0]  force_dcm_o,
  input logic [1:0]  ramp_down_o,
  input logic [15:0] target_frac0_o
);
  // Run lengths of raw inputs; the synchronizers only make the design see them later.
  logic [15:0] uv_run;
  logic [3:0]  vin_run;
  always @(posedge clk_i) begin
    uv_run  <= vout_above_uv_i[0] ? uv_run + {15'h0000, ~&uv_run} : 16'h0000;
    vin_run <= vin_above_on_i ? vin_run + {3'h0, ~&vin_run} : 4'h0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_load_pulse;
    nvm_load_o ##1 !nvm_load_o;
  endsequence
  property p_answer;
    s_req |=> wb_ack_o != wb_err_o;
  endproperty
  property p_load;
    $past(rst_i) |-> ##[0:3] s_load_pulse;
  endproperty
  property p_crc_runs;
    alert_oe_o |-> run_oe_o == 2'b11;
  endproperty
  property p_recovery_off;
    !alert_oe_o && !$past(alert_oe_o) && $past(bus_addr_i) == `ADDR_RECOVERY
      |-> !bus_addr_match_o;
  endproperty
  property p_recovery_on;
    alert_oe_o && $past(alert_oe_o) |-> bus_addr_match_o ==
      ($past(bus_addr_i) inside {`ADDR_RECOVERY, `ADDR_GLOBAL0, `ADDR_GLOBAL1});
  endproperty
  property p_init_hold;
    $past(rst_i) |-> run_oe_o == 2'b11 && fault_oe_o == 2'b11 &&
      power_good_output_o == 2'b00 && shared_time_base_oe_o;
  endproperty
  property p_release;
    $fell(run_oe_o[0]) |-> vin_run >= 4'h2 && !alert_oe_o;
  endproperty
  property p_dcm_ramp;
    pwm_enable_o[0] && !ramp_down_o[0] && target_frac0_o != 16'hFFFF |-> force_dcm_o[0];
  endproperty
  property p_pg_filter;
    $rose(power_good_output_o[0]) |-> uv_run >= `PG_FILTER_CYCLES;
  endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered once");
  a_load: assert property (p_load) else $error("no load pulse after reset");
  a_crc_runs: assert property (p_crc_runs) else $error("runs free with alert");
  a_recovery_off: assert property (p_recovery_off) else $error("recovery addr live");
  a_recovery_on: assert property (p_recovery_on) else $error("bad match on error");
  a_init_hold: assert property (p_init_hold) else $error("outputs not held in init");
  a_release: assert property (p_release) else $error("run released too early");
  a_dcm_ramp: assert property (p_dcm_ramp) else $error("ramp not in dcm");
  a_pg_filter: assert property (p_pg_filter) else $error("power good not filtered");
endmodule

bind rail_sequencing_control rail_seq_chk u_rail_seq_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_err_o, .vin_above_on_i, .vout_above_uv_i, .bus_addr_i,
  .bus_addr_match_o, .nvm_load_o, .run_oe_o, .alert_oe_o, .shared_time_base_oe_o,
  .fault_oe_o, .power_good_output_o, .pwm_enable_o, .force_dcm_o, .ramp_down_o,
  .target_frac0_o);

/* File: tb/rail_peer.sv */
/* Peer regulator sharing the pulled-up run and time-base lines.
   Assumes the bench steers hold_i and clk_en_i just after a clock edge. */
`timescale 1ns/1ps
module rail_peer (
  input  logic       clk_i,
  input  logic [1:0] hold_i,
  input  logic       clk_en_i,
  input  logic [1:0] run_oe_i,
  input  logic       tb_oe_i,
  output logic [1:0] run_o,
  output logic       tb_o
);
  logic [1:0] phase = 2'b00;
  always @(posedge clk_i) begin
    phase <= clk_en_i ? phase + 2'b01 : phase;
  end
  assign run_o = ~(run_oe_i | hold_i);
  // Stopped, the line rests at its pull-up, which reads as not clocking.
  assign tb_o = ~(tb_oe_i | (clk_en_i & phase[1]));
endmodule

/* File: tb/rail_sequencing_control_tb.sv */
/* Self-checking bench for rail_sequencing_control with a peer on the shared lines.
   Assumes the design header and a shortened initialization count. */
`timescale 1ns/1ps
`include "rail_seq_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge clk_i);
module rail_sequencing_control_tb;
  localparam int INIT = 100;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, wb_err_o, bus_addr_match_o, nvm_load_o, use_resistors_o;
  logic        nvm_crc_ok_i = 1'b0;
  logic        vin_above_on_i = 1'b0;
  logic [3:0]  address_select_input_i = 4'h0;
  logic [1:0]  vout_above_uv_i = 2'b00;
  logic [1:0]  overcurrent_i = 2'b00;
  logic [6:0]  bus_addr_i = 7'h00;
  logic [1:0]  peer_hold = 2'b00;
  logic        peer_clk_en = 1'b1;
  logic [1:0]  run_pin_i, run_oe_o, fault_oe_o, power_good_output_o;
  logic [1:0]  pwm_enable_o, force_dcm_o, ramp_down_o;
  logic        shared_time_base_i, alert_oe_o, shared_time_base_oe_o;
  logic [6:0]  bus_address_o, own;
  logic [15:0] target_frac0_o, target_frac1_o;
  int          checked = 0;
  int          miscompares = 0;

  always #5 clk_i = ~clk_i;

  rail_sequencing_control #(.INIT_CYCLES(INIT)) u_rail_sequencing_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .nvm_load_done_i(1'b1), .nvm_crc_ok_i(nvm_crc_ok_i), .res_present_i(1'b1),
    .address_select_input_i(address_select_input_i), .address_select_open_i(2'b00),
    .vin_above_on_i(vin_above_on_i), .vin_above_prog_i(1'b0), .run_pin_i(run_pin_i),
    .shared_time_base_i(shared_time_base_i), .vout_above_uv_i(vout_above_uv_i),
    .overcurrent_i(overcurrent_i), .fault_in_i(2'b00), .bus_addr_i(bus_addr_i),
    .bus_addr_match_o(bus_addr_match_o), .nvm_load_o(nvm_load_o),
    .use_resistors_o(use_resistors_o), .bus_address_o(bus_address_o),
    .run_oe_o(run_oe_o), .alert_oe_o(alert_oe_o),
    .shared_time_base_oe_o(shared_time_base_oe_o), .fault_oe_o(fault_oe_o),
    .power_good_output_o(power_good_output_o), .pwm_enable_o(pwm_enable_o),
    .force_dcm_o(force_dcm_o), .ramp_down_o(ramp_down_o),
    .target_frac0_o(target_frac0_o), .target_frac1_o(target_frac1_o));

  rail_peer u_rail_peer (.clk_i(clk_i), .hold_i(peer_hold), .clk_en_i(peer_clk_en),
    .run_oe_i(run_oe_o), .tb_oe_i(shared_time_base_oe_o), .run_o(run_pin_i),
    .tb_o(shared_time_base_i));

  function automatic logic exp_match(input logic [6:0] a, input logic bad);
    if (a == `ADDR_GLOBAL0 || a == `ADDR_GLOBAL1) return 1'b1;
    return bad ? (a == `ADDR_RECOVERY) : (a == own);
  endfunction

  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    e = wb_err_o;
    if (n >= 20) miscompares++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    wb(1'b1, a, d, q, e);
    `CHK(e, 1'b0)
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic        e;
    wb(1'b0, a, 32'h0, q, e);
    `CHK(q & m, exp)
  endtask

  task automatic probe_match(input logic bad);
    logic [6:0] list[$];
    list = '{`ADDR_RECOVERY, `ADDR_GLOBAL0, `ADDR_GLOBAL1, own};
    foreach (list[i]) begin
      bus_addr_i <= list[i];
      repeat (2) @(posedge clk_i);
      `CHK(bus_addr_match_o, exp_match(list[i], bad))
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    q = $urandom(32'hB256);
    address_select_input_i <= q[3:0];
    own = {1'b1, q[3:2], 2'b00, q[1:0]};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    `WAITC(alert_oe_o === 1'b1, INIT + 50)
    `CHK({alert_oe_o, run_oe_o}, 3'b111)
    `CHK({fault_oe_o, power_good_output_o}, 4'b1100)
    rd(`REG_STATUS, 32'h3, 32'h7);
    probe_match(1'b1);
    wb(1'b0, 6'h3C, 32'h0, q, e);
    `CHK(e, 1'b1)
    $display("test crc_fail done");
    nvm_crc_ok_i <= 1'b1;
    wr(`REG_CONTROL, 32'h4);
    `WAITC(nvm_load_o === 1'b1, 10)
    `CHK(nvm_load_o, 1'b1)
    repeat (INIT + 50) @(posedge clk_i);
    `CHK({alert_oe_o, run_oe_o}, 3'b011)
    rd(`REG_STATUS, 32'h0, 32'h3);
    `CHK(bus_address_o, own)
    rd(`REG_ADDR, {25'h0, own}, 32'hFFFFFFFF);
    `CHK(use_resistors_o, 1'b1)
    probe_match(1'b0);
    wr(`REG_TON_DELAY, 32'h0);
    wr(`REG_TON_RISE, 32'hFA);
    wr(`REG_TON_MAX, 32'h0);
    wr(`REG_TOFF_DELAY, 32'h0);
    wr(`REG_CHAN_CFG, 32'h4);
    // The time base must look idle before run releases, or the run edge starts both rails.
    peer_clk_en <= 1'b0;
    repeat (1100) @(posedge clk_i);
    vin_above_on_i <= 1'b1;
    `WAITC(run_oe_o === 2'b00, 20)
    `CHK({run_oe_o, shared_time_base_oe_o}, 3'b000)
    rd(`REG_STATUS, 32'h4, 32'h7);
    $display("test restore done");
    wr(`REG_CONTROL, 32'h1);
    repeat (200) @(posedge clk_i);
    `CHK({pwm_enable_o, target_frac0_o}, 18'h0)
    peer_clk_en <= 1'b1;
    wr(`REG_CHAN_CFG, 32'h0);
    `WAITC(pwm_enable_o[0] === 1'b1, 50)
    repeat (5) @(posedge clk_i);
    `CHK({pwm_enable_o, force_dcm_o[0], target_frac0_o == 16'hFFFF}, 4'b0110)
    wr(`REG_TON_RISE, 32'h0);
    overcurrent_i <= 2'b10;
    wr(`REG_CONTROL, 32'h3);
    `WAITC(pwm_enable_o[1] === 1'b1, 50)
    repeat (5) @(posedge clk_i);
    `CHK({pwm_enable_o, target_frac1_o}, 18'h3FFFF)
    vout_above_uv_i <= 2'b11;
    `WAITC(power_good_output_o === 2'b11, 6200)
    `CHK(power_good_output_o, 2'b11)
    `CHK(force_dcm_o, 2'b11)
    overcurrent_i <= 2'b00;
    repeat (5) @(posedge clk_i);
    `CHK(force_dcm_o, 2'b01)
    $display("test turn_on done");
    wr(`REG_CONTROL, 32'h2);
    peer_hold <= 2'b01;
    `WAITC(pwm_enable_o[0] === 1'b0, 50)
    repeat (2) @(posedge clk_i);
    `CHK({ramp_down_o[0], pwm_enable_o[1], run_oe_o[0]}, 3'b011)
    wr(`REG_CONTROL, 32'h10);
    peer_hold <= 2'b11;
    `WAITC(ramp_down_o[1] === 1'b1, 50)
    `CHK({ramp_down_o[1], force_dcm_o[1]}, 2'b10)
    peer_hold <= 2'b00;
    repeat (1000) @(posedge clk_i);
    `CHK(run_oe_o, 2'b11)
    $display("test shutdown done");
    wr(`REG_GLOBAL_CFG, 32'h40);
    wr(`REG_CONTROL, 32'h8);
    `WAITC(nvm_load_o === 1'b1, 10)
    `CHK(nvm_load_o, 1'b1)
    `CHK({run_oe_o, fault_oe_o, power_good_output_o}, 6'h3C)
    repeat (INIT + 50) @(posedge clk_i);
    `CHK(use_resistors_o, 1'b0)
    $display("test vendor_reset done");
    stop_test();
  end
endmodule
